// ===== common/spi_cmd_cfg.svh
// Constants for the command-driven SPI master
`ifndef SPI_CMD_CFG_SVH
`define SPI_CMD_CFG_SVH
`define OPT_AUTO_SELECT_BIT 7
`define OPT_SKIP_DIR_BIT 6
`define OPT_MODE_HI 1
`define OPT_MODE_LO 0
`define MODE_A 2'h0
`define MODE_B 2'h1
`define MODE_C 2'h2
`define MODE_D 2'h3
`define RATE_BASE_HZ 1000000
`define RATE_FIXED_TERM 8
`define RATE_STEP_TERM 10
`define DIVIDER_SPAN 256
`define CLK_SYS_HZ 250000000
`define MAX_TRANSFER_LEN 8'hf0
`define LINE_COUNT 23
`endif

// ===== common/spi_cmd_pkg.sv
// Types for the command-driven SPI master
package spi_cmd_pkg;
	typedef struct packed {
		logic auto_select;
		logic skip_direction_setup;
		logic [1:0] clock_shape_select;
		logic [7:0] clock_divider_byte;
		logic [4:0] select_line_index;
		logic [4:0] clock_line_index;
		logic [4:0] inbound_line_index;
		logic [4:0] outbound_line_index;
		logic [7:0] transfer_length;
	} spi_cmd_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_LEAD = 3'b010,
		ST_TRAIL = 3'b011,
		ST_DONE = 3'b100
	} spi_state_t;
endpackage

// ===== hw/spi_cmd_master.sv
// SPI master engine running one full-duplex transfer per command
`timescale 1ns/1ps
`include "spi_cmd_cfg.svh"
// Function
// - Options bits 1-0 select mode A to D
// - Modes map to fixed CPHA and CPOL pairs
// - CPHA picks which clock edge samples data
// - Clock idles at CPOL between bits
// - Clock idle before select falls and rises
// - Auto select low during whole transfer
// - Optionally set line directions for transfer
// - Bit rate follows divider byte formula
// - Each function routed to chosen line 0-22
// - Shift exactly 1 to 240 bytes
// - Full duplex: one byte in per out
module spi_cmd_master
	import spi_cmd_pkg::*;
#(
	parameter int LINES = `LINE_COUNT
)
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire spi_cmd_t cmd,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_byte,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	output logic done,
	output logic [7:0] transferred_length,
	input wire logic [LINES-1:0] line_in,
	output logic [LINES-1:0] line_out,
	output logic [LINES-1:0] line_oe_n
);
	// Half period in system clocks: (8 + 10*(256-f)) us / 2
	function automatic logic [31:0] half_period(input logic [7:0] f);
		logic [31:0] span;
		logic [63:0] num;
		span = (f == 8'h00) ? 32'(`DIVIDER_SPAN) : 32'(`DIVIDER_SPAN) - 32'(f);
		num = 64'(`RATE_FIXED_TERM + `RATE_STEP_TERM * span) * 64'(`CLK_SYS_HZ);
		half_period = 32'(num / 64'(2 * `RATE_BASE_HZ));
	endfunction

	spi_state_t state_r, state_nxt;
	spi_cmd_t cfg_r, cfg_nxt;
	logic cpol_r, cpol_nxt, cpha_r, cpha_nxt;
	logic [31:0] half_r, half_nxt, cnt_r, cnt_nxt;
	logic [2:0] bit_r, bit_nxt;
	logic [7:0] left_r, left_nxt, sent_r, sent_nxt;
	logic [7:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt;
	logic sck_r, sck_nxt, sel_r, sel_nxt, mosi_r, mosi_nxt;
	logic have_r, have_nxt;
	logic [LINES-1:0] out_r, out_nxt, oen_r, oen_nxt;
	logic rxv_r, rxv_nxt, done_r, done_nxt;
	logic [7:0] rxb_r, rxb_nxt, tl_r, tl_nxt;
	logic miso;

	assign miso = line_in[cfg_r.inbound_line_index];
	assign cmd_ready = (state_r == ST_IDLE);
	assign tx_ready = (state_r == ST_SETUP) && !have_r;
	assign rx_valid = rxv_r;
	assign rx_byte = rxb_r;
	assign done = done_r;
	assign transferred_length = tl_r;
	assign line_out = out_r;
	assign line_oe_n = oen_r;

	always_comb
	begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		cpol_nxt = cpol_r;
		cpha_nxt = cpha_r;
		half_nxt = half_r;
		cnt_nxt = cnt_r;
		bit_nxt = bit_r;
		left_nxt = left_r;
		sent_nxt = sent_r;
		tsh_nxt = tsh_r;
		rsh_nxt = rsh_r;
		sck_nxt = sck_r;
		sel_nxt = sel_r;
		mosi_nxt = mosi_r;
		have_nxt = have_r;
		oen_nxt = oen_r;
		rxv_nxt = 1'b0;
		rxb_nxt = rxb_r;
		done_nxt = 1'b0;
		tl_nxt = tl_r;
		unique case (state_r)
			ST_IDLE:
			begin
				if (cmd_valid)
				begin
					cfg_nxt = cmd;
					// Mode B and D idle low, A and C high; A and B sample on return edge
					unique case (cmd.clock_shape_select)
						`MODE_A: begin cpha_nxt = 1'b1; cpol_nxt = 1'b1; end
						`MODE_B: begin cpha_nxt = 1'b1; cpol_nxt = 1'b0; end
						`MODE_C: begin cpha_nxt = 1'b0; cpol_nxt = 1'b1; end
						`MODE_D: begin cpha_nxt = 1'b0; cpol_nxt = 1'b0; end
					endcase
					half_nxt = half_period(cmd.clock_divider_byte);
					// Zero or oversized lengths are clamped into 1..240
					left_nxt = (cmd.transfer_length == 8'h00) ? 8'h01 :
						((cmd.transfer_length > `MAX_TRANSFER_LEN) ? `MAX_TRANSFER_LEN : cmd.transfer_length);
					sent_nxt = 8'h00;
					have_nxt = 1'b0;
					if (!cmd.skip_direction_setup)
					begin
						oen_nxt[cmd.select_line_index] = 1'b0;
						oen_nxt[cmd.clock_line_index] = 1'b0;
						oen_nxt[cmd.outbound_line_index] = 1'b0;
						oen_nxt[cmd.inbound_line_index] = 1'b1;
					end
					state_nxt = ST_SETUP;
				end
			end
			ST_SETUP:
			begin
				sck_nxt = cpol_r;
				if (have_r)
				begin
					// Select falls only once the clock already rests idle
					if (sck_r == cpol_r)
					begin
						sel_nxt = 1'b0;
						bit_nxt = 3'h7;
						cnt_nxt = half_r;
						mosi_nxt = cpha_r ? mosi_r : tsh_r[7];
						state_nxt = ST_LEAD;
					end
				end
				else if (tx_valid)
				begin
					tsh_nxt = tx_byte;
					have_nxt = 1'b1;
				end
			end
			ST_LEAD:
			begin
				if (cnt_r > 32'h1)
					cnt_nxt = cnt_r - 32'h1;
				else
				begin
					cnt_nxt = half_r;
					sck_nxt = ~cpol_r;
					if (cpha_r)
						mosi_nxt = tsh_r[7];
					else
						rsh_nxt = {rsh_r[6:0], miso};
					state_nxt = ST_TRAIL;
				end
			end
			ST_TRAIL:
			begin
				if (cnt_r > 32'h1)
					cnt_nxt = cnt_r - 32'h1;
				else
				begin
					cnt_nxt = half_r;
					sck_nxt = cpol_r;
					tsh_nxt = {tsh_r[6:0], 1'b0};
					if (cpha_r)
						rsh_nxt = {rsh_r[6:0], miso};
					else
						mosi_nxt = tsh_r[6];
					if (bit_r != 3'h0)
					begin
						bit_nxt = bit_r - 3'h1;
						state_nxt = ST_LEAD;
					end
					else
					begin
						rxv_nxt = 1'b1;
						rxb_nxt = cpha_r ? {rsh_r[6:0], miso} : rsh_r;
						sent_nxt = sent_r + 8'h1;
						left_nxt = left_r - 8'h1;
						have_nxt = 1'b0;
						// Select is held low between bytes
						state_nxt = (left_r == 8'h1) ? ST_DONE : ST_SETUP;
					end
				end
			end
			ST_DONE:
			begin
				if (cnt_r > 32'h1)
					cnt_nxt = cnt_r - 32'h1;
				else
				begin
					sel_nxt = 1'b1;
					done_nxt = 1'b1;
					tl_nxt = sent_r;
					state_nxt = ST_IDLE;
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// Route the function signals onto the chosen lines
	always_comb
	begin
		out_nxt = out_r;
		if (cfg_r.auto_select)
			out_nxt[cfg_r.select_line_index] = sel_nxt;
		out_nxt[cfg_r.outbound_line_index] = mosi_nxt;
		out_nxt[cfg_r.clock_line_index] = sck_nxt;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			cfg_r <= '0;
			cpol_r <= 1'b0;
			cpha_r <= 1'b0;
			half_r <= 32'h1;
			cnt_r <= 32'h1;
			bit_r <= 3'h0;
			left_r <= 8'h00;
			sent_r <= 8'h00;
			tsh_r <= 8'h00;
			rsh_r <= 8'h00;
			sck_r <= 1'b0;
			sel_r <= 1'b1;
			mosi_r <= 1'b0;
			have_r <= 1'b0;
			out_r <= '1;
			oen_r <= '1;
			rxv_r <= 1'b0;
			rxb_r <= 8'h00;
			done_r <= 1'b0;
			tl_r <= 8'h00;
		end
		else
		begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			cpol_r <= cpol_nxt;
			cpha_r <= cpha_nxt;
			half_r <= half_nxt;
			cnt_r <= cnt_nxt;
			bit_r <= bit_nxt;
			left_r <= left_nxt;
			sent_r <= sent_nxt;
			tsh_r <= tsh_nxt;
			rsh_r <= rsh_nxt;
			sck_r <= sck_nxt;
			sel_r <= sel_nxt;
			mosi_r <= mosi_nxt;
			have_r <= have_nxt;
			out_r <= out_nxt;
			oen_r <= oen_nxt;
			rxv_r <= rxv_nxt;
			rxb_r <= rxb_nxt;
			done_r <= done_nxt;
			tl_r <= tl_nxt;
		end
	end
endmodule // spi_cmd_master

// ===== tb/command_driven_spi_master_tb_top.sv
// Testbench for the command-driven SPI master
`timescale 1ns/1ps
module command_driven_spi_master_tb_top;
	import spi_cmd_pkg::*;
	logic clk_sys = 1'b0, resetn = 1'b0, cmd_valid = 1'b0, tx_valid = 1'b0;
	logic cpol = 1'b0, cpha = 1'b0, sel_prev = 1'b1;
	logic [7:0] tx_byte = 8'h00, reply = 8'h00;
	spi_cmd_t cmd = '0;
	logic cmd_ready, tx_ready, rx_valid, done, miso;
	logic [7:0] rx_byte, transferred_length, got;
	logic [22:0] line_in, line_out, line_oe_n;
	logic [1:0] modes [2] = '{2'h2, 2'h1};
	logic [7:0] lens [2] = '{8'h01, 8'h00};
	int bad_count = 0;
	int samples_checked = 0;
	always #2 clk_sys = ~clk_sys;
	// Released lines pull high; the slave answers on line 17
	always_comb
		for (int i = 0; i < 23; i++)
			line_in[i] = !line_oe_n[i] ? line_out[i] : (i == 17 ? miso : 1'b1);
	spi_cmd_master uut (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_byte(rx_byte), .done(done),
		.transferred_length(transferred_length), .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n));
	spi_slave_model slave (.sel_n(line_in[3]), .sck(line_in[10]), .mosi(line_in[22]), .cpol(cpol), .cpha(cpha),
		.reply(reply), .miso(miso), .got(got));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic check(input logic [7:0] act, input logic [7:0] exp);
		samples_checked++;
		if (act !== exp)
		begin
			bad_count++;
			$display("BAD t=%0t got %h want %h", $time, act, exp);
		end
	endtask
	task automatic wait_hi(input int which);
		int n;
		n = 0;
		while (!(which == 0 ? tx_ready : which == 1 ? rx_valid : which == 2 ? done : cmd_ready))
		begin
			@(negedge clk_sys);
			n++;
			if (n > 50000)
			begin
				bad_count++;
				end_sim();
			end
		end
	endtask
	// Clock must rest at its idle level when select falls
	always @(negedge clk_sys)
	begin
		if (sel_prev && !line_in[3] && resetn)
			check({7'h00, line_in[10]}, {7'h00, cpol});
		sel_prev = line_in[3];
	end
	initial
	begin
		repeat (8) @(negedge clk_sys);
		resetn = 1'b1;
		for (int i = 0; i < 2; i++)
		begin
			cpha = !modes[i][1];
			cpol = !modes[i][0];
			reply = i ? 8'h3a : 8'hc5;
			cmd = '{1'b1, i[0], modes[i], 8'hff, 5'h03, 5'h0a, 5'h11, 5'h16, lens[i]};
			wait_hi(3);
			cmd_valid = 1'b1;
			@(negedge clk_sys);
			cmd_valid = 1'b0;
			wait_hi(0);
			tx_valid = 1'b1;
			tx_byte = ~reply;
			@(negedge clk_sys);
			tx_valid = 1'b0;
			check({4'h0, line_oe_n[3], line_oe_n[10], line_oe_n[17], line_oe_n[22]}, 8'h02);
			wait_hi(1);
			check({7'h00, line_in[3]}, 8'h00);
			check(rx_byte, reply);
			check(got, ~reply);
			wait_hi(2);
			check(transferred_length, 8'h01);
			@(negedge clk_sys);
			check({6'h00, line_in[3], line_in[10]}, {6'h00, 1'b1, cpol});
			$display("test %0d ended", i);
		end
		end_sim();
	end
endmodule // command_driven_spi_master_tb_top

// ===== tb/spi_cmd_chk.sv
// Port assertions for the SPI command master
`timescale 1ns/1ps
module spi_cmd_chk #(parameter int LINES = 23) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic tx_ready,
	input wire logic rx_valid,
	input wire logic done,
	input wire logic [LINES-1:0] line_oe_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	sequence s_take;
		cmd_valid && cmd_ready;
	endsequence
	chk_busy_refuse: assert property (s_take |=> !cmd_ready) else $error("busy not shown");
	chk_tx_offer: assert property (s_take |-> ##[1:2] tx_ready) else $error("no byte request");
	chk_rx_single: assert property (rx_valid |=> !rx_valid) else $error("rx pulse long");
	chk_done_single: assert property (done |=> !done) else $error("done pulse long");
	chk_done_idle: assert property (done |-> ##[0:2] cmd_ready) else $error("not idle after done");
	chk_dir_hold: assert property (cmd_ready && !cmd_valid |=> $stable(line_oe_n)) else $error("dir moved");
	chk_rx_busy: assert property (rx_valid |-> !cmd_ready && !done) else $error("rx while idle");
	chk_done_notx: assert property (done |-> !tx_ready) else $error("byte asked at end");
endmodule // spi_cmd_chk
bind spi_cmd_master spi_cmd_chk #(.LINES(LINES)) chk_i (.clk_sys(clk_sys), .resetn(resetn), .cmd_valid(cmd_valid),
	.cmd_ready(cmd_ready), .tx_ready(tx_ready), .rx_valid(rx_valid), .done(done), .line_oe_n(line_oe_n));

// ===== tb/spi_slave_model.sv
// Behavioural SPI slave on the far side
`timescale 1ns/1ps
module spi_slave_model (
	input wire logic sel_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] reply,
	output logic miso,
	output logic [7:0] got
);
	logic [7:0] sh;
	initial miso = 1'b0;
	// Released line shows the inverse of its last level
	always @(posedge sel_n) miso = ~miso;
	always @(negedge sel_n)
	begin
		sh = reply;
		miso = cpha ? ~reply[7] : reply[7];
	end
	always @(sck)
		if (!sel_n && ((sck != cpol) ^ cpha))
			got = {got[6:0], mosi};
		else if (!sel_n)
		begin
			if (!cpha) sh = sh << 1;
			miso = sh[7];
			if (cpha) sh = sh << 1;
		end
endmodule // spi_slave_model
